// ---- common/reset_watchdog_pkg.sv ----
// Constants for the reset-source and watchdog block.
// Assumes a 20 MHz system clock and a 32-bit APB register port.
package reset_watchdog_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ           = 20000000;
	localparam int unsigned LF_CLK_HZ        = 16000;
	localparam int unsigned LF_DIV           = CLK_HZ / LF_CLK_HZ;
	localparam int unsigned PAD_QUAL_US      = 1000;
	localparam int unsigned PAD_QUAL_CYC     = (CLK_HZ / 1000000) * PAD_QUAL_US;
	localparam int unsigned LV_QUAL_US       = 10;
	localparam int unsigned LV_QUAL_CYC      = (CLK_HZ / 1000000) * LV_QUAL_US;
	localparam int unsigned RST_STRETCH_CYC  = 4;

	// Watchdog timeouts in milliseconds, normal and fast sets
	localparam int unsigned WD_MS_0  = 32;
	localparam int unsigned WD_MS_1  = 128;
	localparam int unsigned WD_MS_2  = 512;
	localparam int unsigned WD_MS_3  = 2048;
	localparam int unsigned WDF_MS_0 = 2;
	localparam int unsigned WDF_MS_1 = 8;
	localparam int unsigned WDF_MS_2 = 16;
	localparam int unsigned WDF_MS_3 = 32;
	localparam int unsigned WD_TICK_W = 16;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_WDCTRL  = 8'h00;
	localparam logic [7:0] ADDR_KEY     = 8'h04;
	localparam logic [7:0] ADDR_CLKCTRL = 8'h08;
	localparam logic [7:0] ADDR_SYSCTRL = 8'h0c;
	localparam logic [7:0] ADDR_CAUSE   = 8'h10;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int unsigned WD_RESTART_BIT = 0;
	localparam int unsigned WD_ENABLE_BIT  = 1;
	localparam int unsigned WD_FLAG_BIT    = 3;
	localparam int unsigned CK_FAST_BIT    = 5;
	localparam int unsigned CK_SEL_LSB     = 6;
	localparam int unsigned SC_LVR_DIS_BIT = 3;
	localparam int unsigned SC_LVD_SEL_LSB = 4;
	localparam int unsigned SC_LVD_STS_BIT = 7;
	localparam int unsigned CS_POR_BIT     = 0;
	localparam int unsigned CS_LVR_BIT     = 1;
	localparam int unsigned CS_WD_BIT      = 2;
	localparam int unsigned CS_PAD_BIT     = 3;
	localparam logic [7:0] CLKCTRL_RST  = 8'h01;
	localparam logic [7:0] KEY_FIRST    = 8'haa;
	localparam logic [7:0] KEY_SECOND   = 8'h55;
	localparam int unsigned NUM_CAUSES  = 8;

	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;

endpackage

// ---- design/reset_sync_stretch.sv ----
// Reset release synchroniser with a short stretch.
// Assumes any cause may arrive asynchronously; release follows clk_in.
`timescale 1ns/1ps
`default_nettype none
module reset_sync_stretch
	import reset_watchdog_pkg::*;
#(
	parameter int unsigned STAGES = RST_STRETCH_CYC
) (
	input  wire logic clk_in,
	input  wire logic any_cause_in,
	output var  logic sys_rst_out
);
	logic [STAGES-1:0] chain_q;

	// Asserted at once, released after STAGES clean edges
	always_ff @(posedge clk_in or posedge any_cause_in) begin
		if (any_cause_in) begin
			chain_q <= '1;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], 1'b0};
		end
	end
	assign sys_rst_out = chain_q[STAGES-1];
endmodule
`default_nettype wire

// ---- design/reset_watchdog.sv ----
// Reset sources, low-voltage detect and key-guarded watchdog.
// Assumes analog comparators give levels synchronous to clk_in, and an APB master.
//
// Overview of operation
// - Eight reset causes each force system reset
// - Power-on reset returns every register to its reset value
// - Low-voltage reset only when enabled, qualified
// - Detect flag follows supply versus threshold
// - Two-bit field picks one of four thresholds
// - Pad reset pin held high over 1 ms
// - Pad reset defaults registers, picks boot start
// - Control bit one enables watchdog reset
// - Restart bit zeroes the watchdog counter
// - Timeout while enabled resets the processor
// - Restart bit clears itself in hardware
// - Watchdog cause flag sticky until software clears
// - Control writes need key pair first
// - Control reads need no key
// - Four timeouts chosen by clock bits 7:6
// - Clock bit five selects fast timeout set
// - Threshold code 00 lowest up to 11
// - Low-voltage reset disable bit, zero enables
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog
	import reset_watchdog_pkg::*;
#(
	parameter int unsigned PAD_QUAL  = PAD_QUAL_CYC,
	parameter int unsigned LF_DIVIDE = LF_DIV,
	parameter bit          FAST_OK   = 1'b1
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        pad_reset_in,
	input  wire logic        supply_below_lvr_in,
	input  wire logic [3:0]  supply_below_lvd_in,
	input  wire logic [3:0]  other_causes_in,
	input  wire logic        boot_loader_flash_in,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        sys_rst_out,
	output var  logic        boot_loader_out
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  wdctrl_q;
	logic [7:0]  clkctrl_q;
	logic [7:0]  sysctrl_q;
	logic [7:0]  cause_q;
	logic        lvd_q;
	logic        boot_sel_q;
	key_state_t  key_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] pad_cnt_q;
	logic [31:0] lv_cnt_q;
	logic [31:0] lf_cnt_q;
	logic [WD_TICK_W-1:0] wd_cnt_q;
	logic        pad_trip_q;
	logic        lvr_trip_q;
	logic        wd_trip_q;
	logic        por_seen_q;
	logic        sys_rst;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire setup_w   = psel && !penable;
	// Writes land in the access cycle, at the edge where pready is seen high;
	// read data are captured at setup so they stand through that cycle.
	wire access_w  = psel && penable && pready_q;
	wire wr_w      = access_w && pwrite;
	wire rd_w      = setup_w && !pwrite;
	wire hit_wd    = paddr == ADDR_WDCTRL;
	wire hit_key   = paddr == ADDR_KEY;
	wire hit_ck    = paddr == ADDR_CLKCTRL;
	wire hit_sc    = paddr == ADDR_SYSCTRL;
	wire hit_cs    = paddr == ADDR_CAUSE;
	wire mapped_w  = hit_wd || hit_key || hit_ck || hit_sc || hit_cs;
	wire [7:0] wbyte = pwdata[7:0];
	wire key_open  = key_q == KEY_OPEN;
	wire wd_wr_ok  = wr_w && hit_wd && key_open;
	wire key_wr    = wr_w && hit_key;

	// ----------------------------------------
	// Watchdog timeout selection
	// ----------------------------------------
	wire [1:0] wd_sel  = clkctrl_q[CK_SEL_LSB +: 2];
	wire       wd_fast = FAST_OK && clkctrl_q[CK_FAST_BIT];
	logic [WD_TICK_W-1:0] wd_limit;
	always_comb begin
		// Ticks = ms * 16 per the slow clock
		// The longest normal choice sits one tick short, at 32767 ticks
		case ({wd_fast, wd_sel})
			3'b000:  wd_limit = WD_TICK_W'(WD_MS_0 * 16);
			3'b001:  wd_limit = WD_TICK_W'(WD_MS_1 * 16);
			3'b010:  wd_limit = WD_TICK_W'(WD_MS_2 * 16);
			3'b011:  wd_limit = WD_TICK_W'(WD_MS_3 * 16 - 1);
			3'b100:  wd_limit = WD_TICK_W'(WDF_MS_0 * 16);
			3'b101:  wd_limit = WD_TICK_W'(WDF_MS_1 * 16);
			3'b110:  wd_limit = WD_TICK_W'(WDF_MS_2 * 16);
			default: wd_limit = WD_TICK_W'(WDF_MS_3 * 16);
		endcase
	end

	// The slow tick runs free; a restart only zeroes the count, so a timeout
	// may land up to one slow tick late.
	wire lf_tick   = lf_cnt_q == LF_DIVIDE - 1;
	wire wd_on     = wdctrl_q[WD_ENABLE_BIT];
	wire restart_w = wdctrl_q[WD_RESTART_BIT];
	wire wd_expire = wd_on && !restart_w && lf_tick && wd_cnt_q >= wd_limit;
	wire [1:0] lvd_sel = sysctrl_q[SC_LVD_SEL_LSB +: 2];
	// Input bit 0 is the lowest threshold, bit 3 the highest
	wire lvd_now   = supply_below_lvd_in[lvd_sel];
	wire lvr_en    = !sysctrl_q[SC_LVR_DIS_BIT];

	// ----------------------------------------
	// Reset combining
	// ----------------------------------------
	// Watchdog and pad trips are stretched by the synchroniser; their trip flags
	// survive system reset because their flops are reset by rst_in, not sys_rst.
	wire [NUM_CAUSES-1:0] causes_w = {other_causes_in, wd_trip_q, pad_trip_q,
		lvr_trip_q, rst_in};
	// Power-on enters without a clock edge; the stretch needs the clock only to let go
	wire any_cause = |causes_w;

	reset_sync_stretch u_rst_sync (
		.clk_in       (clk_in),
		.any_cause_in (any_cause),
		.sys_rst_out  (sys_rst)
	);

	// ----------------------------------------
	// Qualifiers and trips, reset by power-on, not by system reset
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pad_cnt_q  <= '0;
			pad_trip_q <= 1'b0;
		end else if (!pad_reset_in) begin
			pad_cnt_q  <= '0;
			pad_trip_q <= 1'b0;
		end else if (pad_cnt_q >= PAD_QUAL) begin
			// Count parks at the limit so a pin held for seconds cannot wrap
			pad_trip_q <= 1'b1;
		end else begin
			pad_cnt_q <= pad_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lv_cnt_q   <= '0;
			lvr_trip_q <= 1'b0;
		end else if (!(supply_below_lvr_in && lvr_en)) begin
			lv_cnt_q   <= '0;
			lvr_trip_q <= 1'b0;
		end else if (lv_cnt_q >= LV_QUAL_CYC) begin
			lvr_trip_q <= 1'b1;
		end else begin
			lv_cnt_q <= lv_cnt_q + 32'h1;
		end
	end

	// Watchdog trip pulses once; the stretch carries the reset
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wd_trip_q <= 1'b0;
		end else begin
			wd_trip_q <= wd_expire && !wd_trip_q;
		end
	end

	// ----------------------------------------
	// Reset cause status, sticky across system reset
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cause_q    <= 8'h00;
			por_seen_q <= 1'b0;
		end else begin
			// Clear-by-writing-one; a new event in the same cycle wins
			cause_q <= (wr_w && hit_cs) ? (cause_q & ~wbyte) : cause_q;
			if (!por_seen_q) begin
				cause_q[CS_POR_BIT] <= 1'b1;
				por_seen_q          <= 1'b1;
			end
			if (lvr_trip_q) cause_q[CS_LVR_BIT] <= 1'b1;
			if (wd_trip_q)  cause_q[CS_WD_BIT]  <= 1'b1;
			if (pad_trip_q) cause_q[CS_PAD_BIT] <= 1'b1;
		end
	end

	// ----------------------------------------
	// Slow tick and watchdog counter
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst) begin
		if (sys_rst) begin
			lf_cnt_q <= '0;
			wd_cnt_q <= '0;
		end else begin
			lf_cnt_q <= lf_tick ? 32'h0 : lf_cnt_q + 32'h1;
			if (restart_w || !wd_on) begin
				wd_cnt_q <= '0;
			end else if (lf_tick && wd_cnt_q != '1) begin
				wd_cnt_q <= wd_cnt_q + WD_TICK_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Key sequence and software registers
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst) begin
		if (sys_rst) begin
			key_q <= KEY_IDLE;
		end else begin
			case (key_q)
				KEY_IDLE: begin
					if (key_wr && wbyte == KEY_FIRST) key_q <= KEY_HALF;
				end
				KEY_HALF: begin
					// A wrong second key starts over, so guessing costs a full pair
					if (key_wr) key_q <= (wbyte == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
				end
				KEY_OPEN: begin
					// One protected write per unlock
					if (wr_w && (hit_wd || hit_key)) key_q <= KEY_IDLE;
				end
				default: key_q <= KEY_IDLE;
			endcase
		end
	end

	// All software registers except the cause status return to defaults on any system reset
	always_ff @(posedge clk_in or posedge sys_rst) begin
		if (sys_rst) begin
			wdctrl_q  <= 8'h00;
			clkctrl_q <= CLKCTRL_RST;
			sysctrl_q <= 8'h00;
			lvd_q     <= 1'b0;
		end else begin
			// Resampled every cycle; software sees a change one cycle late
			lvd_q <= lvd_now;
			if (wd_wr_ok) begin
				wdctrl_q <= wbyte;
			end else begin
				wdctrl_q[WD_RESTART_BIT] <= 1'b0;
			end
			if (wr_w && hit_ck) clkctrl_q <= wbyte;
			if (wr_w && hit_sc) sysctrl_q <= {1'b0, wbyte[6:0]};
		end
	end

	// Boot start chosen at release from reset
	// Sampled all through system reset once power-on has ended, so the flash choice has settled by release
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			boot_sel_q <= 1'b0;
		end else if (sys_rst) begin
			boot_sel_q <= boot_loader_flash_in;
		end
	end

	// ----------------------------------------
	// APB answer, one wait-free access cycle
	// ----------------------------------------
	wire [7:0] rd_byte = hit_wd ? wdctrl_q :
		hit_key ? 8'h00 :
		hit_ck  ? clkctrl_q :
		hit_sc  ? {lvd_q, sysctrl_q[6:0]} :
		hit_cs  ? cause_q : 8'h00;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_w;
			pslverr_q <= setup_w && !mapped_w;
			prdata_q  <= rd_w ? {24'h0, rd_byte} : 32'h0;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
	assign sys_rst_out     = sys_rst;
	assign boot_loader_out = boot_sel_q;
endmodule
`default_nettype wire

// ---- bench/pad_pin_drv.sv ----
// Model of the party driving the external reset pin.
// Assumes the bench calls press from the same clock domain as the block.
`timescale 1ns/1ps
`default_nettype none
module pad_pin_drv (
	input  wire logic clk_in,
	output var  logic pad_out
);
	initial pad_out = 1'h0;
	// Holds the pin high for n whole cycles; short holds must not reset
	task automatic press(input int n);
		@(posedge clk_in);
		pad_out <= 1'h1;
		repeat (n) @(posedge clk_in);
		pad_out <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- bench/reset_watchdog_chk.sv ----
// Port-level checks of reset gathering and supply control.
// Assumes it is bound into reset_watchdog; mirrors supply fields from APB writes.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_chk
	import reset_watchdog_pkg::*;
#(
	parameter int unsigned PAD_QUAL = PAD_QUAL_CYC
) (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        pad_reset_in,
	input wire logic        supply_below_lvr_in,
	input wire logic [3:0]  supply_below_lvd_in,
	input wire logic [3:0]  other_causes_in,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        sys_rst_out
);
	localparam int LV_LIM = LV_QUAL_CYC + 6;
	logic [1:0] sel_q;
	logic       dis_q;
	int         pad_q;
	int         lv_q;
	wire logic  rd_ok  = psel && penable && pready && !pwrite;
	wire logic  wr_ok  = psel && penable && pready && pwrite;
	wire logic  sys_rd = rd_ok && paddr == ADDR_SYSCTRL;
	// Writes landing during system reset are dropped, as in the block
	always_ff @(posedge clk_in) begin
		if (sys_rst_out) begin
			sel_q <= 2'h0;
			dis_q <= 1'h0;
		end else if (wr_ok && paddr == ADDR_SYSCTRL) begin
			sel_q <= pwdata[5:4];
			dis_q <= pwdata[SC_LVR_DIS_BIT];
		end
	end
	// Low run counts only while enabled, so a late enable restarts qualification
	always_ff @(posedge clk_in) begin
		pad_q <= pad_reset_in ? pad_q + 1 : 0;
		lv_q <= (supply_below_lvr_in && !dis_q) ? lv_q + 1 : 0;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence cause_up;
		other_causes_in != 4'h0;
	endsequence
	sequence sys_up;
		##[0:3] sys_rst_out;
	endsequence
	a_por_reset: assert property (disable iff (1'h0) rst_in |-> sys_rst_out)
		else $error("power-on reset not forwarded");
	a_cause_reset: assert property (cause_up |-> sys_up)
		else $error("reset cause not forwarded");
	a_release_sync: assert property ($fell(sys_rst_out) |->
		!$past(rst_in, 4) && $past(other_causes_in, 4) == 4'h0)
		else $error("reset released too early");
	a_pad_qualify: assert property (pad_q >= PAD_QUAL + 6 |-> sys_rst_out)
		else $error("held pad did not reset");
	a_lvr_enabled: assert property (lv_q >= LV_LIM |-> sys_rst_out)
		else $error("low supply did not reset");
	a_restart_clear: assert property (rd_ok && paddr == ADDR_WDCTRL |->
		!prdata[WD_RESTART_BIT])
		else $error("restart bit reads set");
	a_lvd_status: assert property (sys_rd && supply_below_lvd_in ==
		$past(supply_below_lvd_in, 4) |->
		prdata[SC_LVD_STS_BIT] == supply_below_lvd_in[sel_q])
		else $error("detect flag wrong");
	a_sel_readback: assert property (sys_rd |-> prdata[5:3] == {sel_q, dis_q})
		else $error("supply fields wrong");
endmodule
bind reset_watchdog reset_watchdog_chk #(.PAD_QUAL(PAD_QUAL)) i_reset_watchdog_chk (.clk_in,
	.rst_in, .pad_reset_in, .supply_below_lvr_in, .supply_below_lvd_in, .other_causes_in,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .sys_rst_out);
`default_nettype wire

// ---- bench/reset_watchdog_tb.sv ----
// Self-checking bench for the reset-source and watchdog block.
// Assumes short pad and slow-tick parameters; APB is driven by tasks below.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_tb;
	import reset_watchdog_pkg::*;
	localparam int LF = 4;
	localparam int PQ = 20;
	localparam int FT [5] = '{WDF_MS_0, WDF_MS_1, WDF_MS_2, WDF_MS_3, WD_MS_0};
	logic        clk_in, rst_in, pad_reset_in, supply_below_lvr_in, boot_loader_flash_in;
	logic [3:0]  supply_below_lvd_in, other_causes_in;
	logic        psel, penable, pwrite, pready, pslverr, sys_rst_out, boot_loader_out, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	int          n_mismatch, checks, wn;
	reset_watchdog #(.PAD_QUAL(PQ), .LF_DIVIDE(LF)) i_reset_watchdog (.clk_in, .rst_in,
		.pad_reset_in, .supply_below_lvr_in, .supply_below_lvd_in, .other_causes_in,
		.boot_loader_flash_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sys_rst_out, .boot_loader_out);
	pad_pin_drv i_pad_pin_drv (.clk_in, .pad_out(pad_reset_in));
	initial begin
		clk_in = 1'h0;
		forever #25 clk_in = ~clk_in;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'h1;
		@(posedge clk_in);
		// Only the bench watchdog ends this wait
		while (pready !== 1'h1) begin
			@(posedge clk_in);
			n++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk("wait states", 0, n);
	endtask
	task wrst(input logic v, input int mx);
		wn = 0;
		while (sys_rst_out !== v && wn < mx) begin
			@(posedge clk_in);
			wn++;
		end
		chk("sys_rst_out", 32'(v), 32'(sys_rst_out));
	endtask
	task unlock;
		apb(ADDR_KEY, 1, 32'(KEY_FIRST));
		apb(ADDR_KEY, 1, 32'(KEY_SECOND));
	endtask
	task t_regs;
		apb(ADDR_CLKCTRL, 0, 0);
		chk("clkctrl", 32'(CLKCTRL_RST), rdat);
		apb(ADDR_CAUSE, 0, 0);
		chk("por cause", 32'h1 << CS_POR_BIT, rdat);
		apb(8'h14, 0, 0);
		chk("unmapped", 1, 32'(rerr));
		apb(ADDR_WDCTRL, 1, 32'h2);
		apb(ADDR_WDCTRL, 0, 0);
		chk("locked", 0, rdat);
		unlock;
		apb(ADDR_WDCTRL, 1, 32'h2);
		apb(ADDR_WDCTRL, 0, 0);
		chk("unlocked", 32'h2, rdat);
		apb(ADDR_KEY, 1, 32'(KEY_FIRST));
		apb(ADDR_KEY, 1, 32'h0);
		apb(ADDR_KEY, 1, 32'(KEY_SECOND));
		apb(ADDR_WDCTRL, 1, 32'h0);
		apb(ADDR_WDCTRL, 0, 0);
		chk("broken key", 32'h2, rdat);
		unlock;
		apb(ADDR_WDCTRL, 1, 32'h0);
	endtask
	task t_restart;
		apb(ADDR_CLKCTRL, 1, 32'h20);
		unlock;
		apb(ADDR_WDCTRL, 1, 32'h3);
		repeat (4) begin
			repeat (80) @(posedge clk_in); // Idles well past one slow tick
			unlock;
			apb(ADDR_WDCTRL, 1, 32'h3);
		end
		chk("kept alive", 0, 32'(sys_rst_out));
		apb(ADDR_WDCTRL, 0, 0);
		chk("restart clear", 32'h2, rdat);
		wrst(1, 200);
		wrst(0, 20);
	endtask
	task t_timeouts;
		int t;
		for (int s = 0; s < 5; s++) begin
			t = FT[s] * 16 * LF;
			// The last pass checks the shortest normal-mode timeout
			apb(ADDR_CLKCTRL, 1, (s < 4) ? 32'((s << 6) | 32'h20) : 32'h0);
			unlock;
			apb(ADDR_WDCTRL, 1, 32'h3);
			wrst(1, t + 100);
			chk("timeout", 1, 32'(wn >= t - 8 && wn <= t + 12));
			wrst(0, 20);
			apb(ADDR_CAUSE, 0, 0);
			chk("wd cause", 1, 32'(rdat[CS_WD_BIT]));
		end
		apb(ADDR_CAUSE, 1, 32'h4);
		apb(ADDR_CAUSE, 0, 0);
		chk("wd cause clear", 0, 32'(rdat[CS_WD_BIT]));
	endtask
	task t_pad;
		boot_loader_flash_in <= 1'h1;
		apb(ADDR_CLKCTRL, 1, 32'hc0);
		i_pad_pin_drv.press(PQ / 2);
		repeat (5) @(posedge clk_in);
		chk("short pad", 0, 32'(sys_rst_out));
		i_pad_pin_drv.press(PQ + 10);
		wrst(1, 2);
		wrst(0, 20);
		chk("boot", 1, 32'(boot_loader_out));
		apb(ADDR_CLKCTRL, 0, 0);
		chk("pad default", 32'(CLKCTRL_RST), rdat);
		boot_loader_flash_in <= 1'h0;
	endtask
	task t_lvd;
		supply_below_lvd_in <= 4'h3;
		for (int s = 0; s < 4; s++) begin
			apb(ADDR_SYSCTRL, 1, 32'((s << 4) | 32'h8));
			repeat (4) @(posedge clk_in);
			apb(ADDR_SYSCTRL, 0, 0);
			chk("lvd flag", 32'(s < 2), 32'(rdat[SC_LVD_STS_BIT]));
		end
		supply_below_lvr_in <= 1'h1;
		repeat (300) @(posedge clk_in);
		chk("lvr off", 0, 32'(sys_rst_out));
		apb(ADDR_SYSCTRL, 1, 32'h0);
		wrst(1, LV_QUAL_CYC + 20);
		supply_below_lvr_in <= 1'h0;
		wrst(0, 30);
	endtask
	task t_other;
		for (int i = 0; i < 4; i++) begin
			other_causes_in <= 4'(1 << i);
			wrst(1, 5);
			other_causes_in <= 4'h0;
			wrst(0, 20);
		end
	endtask
	task t_por;
		rst_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'h0;
		wrst(0, 20);
		apb(ADDR_CAUSE, 0, 0);
		chk("por wipes causes", 32'h1 << CS_POR_BIT, rdat);
		chk("boot after por", 0, 32'(boot_loader_out));
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		rst_in = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{supply_below_lvr_in, supply_below_lvd_in, other_causes_in} = '0;
		boot_loader_flash_in = 1'h0;
		// Reset rises on a clock edge so no check samples it racing time zero
		@(posedge clk_in);
		rst_in <= 1'h1;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'h0;
		wrst(0, 20);
		t_regs;
		t_restart;
		t_timeouts;
		t_pad;
		t_lvd;
		t_other;
		t_por;
		give_verdict;
	end
	initial begin
		repeat (15000) @(posedge clk_in);
		n_mismatch++;
		give_verdict;
	end
endmodule
`default_nettype wire
